/* File: core/autoreload_timer_pkg.sv */
// Constants shared by the auto-reload timer with PWM channel
package autoreload_timer_pkg;
   // ---------------------------------------------------------------
   // Register indices (printed offsets, byte address is four times)
   // ---------------------------------------------------------------
   localparam logic [7:0] idx_timer_control_status = 8'h0d;
   localparam logic [7:0] idx_counter_high = 8'h0e;
   localparam logic [7:0] idx_counter_low = 8'h0f;
   localparam logic [7:0] idx_reload_high = 8'h10;
   localparam logic [7:0] idx_reload_low = 8'h11;
   localparam logic [7:0] idx_output_control = 8'h12;
   localparam logic [7:0] idx_channel_control_status = 8'h13;
   localparam logic [7:0] idx_duty_high = 8'h17;
   localparam logic [7:0] idx_duty_low = 8'h18;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int clk_sel_hi = 4;
   localparam int clk_sel_lo = 3;
   localparam int ovf_bit = 2;
   localparam int overflow_irq_enable_bit = 1;
   localparam int compare_irq_enable_bit = 0;
   localparam int polarity_bit = 1;
   localparam int cmpf_bit = 0;
   localparam int oe_bit = 0;
   // ---------------------------------------------------------------
   // Clock select codes, reset values, counter limits
   // ---------------------------------------------------------------
   localparam logic [1:0] clk_off = 2'h0;
   localparam logic [1:0] clk_lite = 2'h1;
   localparam logic [1:0] clk_cpu = 2'h2;
   localparam logic [7:0] reg_reset = 8'h00;
   localparam logic [11:0] count_max = 12'hfff;
   localparam logic [11:0] word_reset = 12'h000;
   // Lite tick timebase: 1 ms at the 125 MHz bus clock
   localparam int tick_period_ns = 1000000;
   localparam int clk_period_ns = 8;
   localparam int tick_cycles = tick_period_ns / clk_period_ns;
   localparam logic [1:0] htrans_nonseq = 2'h2;
   localparam logic [2:0] hsize_word = 3'h2;
endpackage

/* File: core/autoreload_timer_pwm.sv */
// Auto-reload 12-bit timer with one PWM / output compare channel on AHB-Lite
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
module autoreload_timer_pwm #(
   parameter int tick_div = autoreload_timer_pkg::tick_cycles // Lite tick divider
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic pulse_output, // Pin level while driven
   output logic pulse_output_oe, // High while the timer drives the pin
   output logic overflow_irq,
   output logic compare_irq
);
   // ---------------------------------------------------------------
   // Overview
   // ---------------------------------------------------------------
   // One clock runs everything. The counter advances on a one-cycle
   // enable, cnt_en, which is high on every bus clock in CPU mode and
   // once per divider period in lite tick mode. Nothing here is a second
   // clock, so no value crosses between domains.
   //
   // Register map: every register is one byte in bits 7:0 of an aligned
   // word; the word index is haddr[9:2]. Bits 31:8 read as zero, and
   // writes to them are ignored. Unmapped indices read as zero.
   //
   // Bus timing: zero wait states. The address phase is sampled at one
   // edge; a write lands at the next edge, when hwdata stands. Read data
   // is registered at the address edge and stands through the data phase.
   // Read side effects, the compare flag clear and the overflow clear arming, happen at the address edge.
   //
   // Counter: 12 bits, counts up, wraps from all ones to the reload value.
   // The wrap sets the overflow flag, loads the shadow duty copy and, in
   // PWM mode, raises the PWM level.
   //
   // Compare: the counter's next value is held against the target. The
   // flag therefore rises in the same cycle as the counter takes the
   // matching value, which keeps the pin edge on the count itself.
   //
   // Duty update: writing the high byte locks compare until the low byte
   // arrives, so in compare mode a half-written value never produces a false match. A
   // user who writes the high byte just before a match loses that match;
   // update right after an overflow when duty is large, right before one
   // when duty is close to the reload value.
   //
   // Overflow clear: a status read only arms the clear. The flag drops at
   // the next counter tick, so in lite tick mode it can read high for up
   // to one tick after software has read it. A new wrap beats the clear.
   //
   // Trade-off: the lite tick divider is a plain 32-bit counter. It costs
   // more flops than a narrow one, but serves any divider width without a
   // second parameter.
   //
   // Outputs are all registered, so each follows its source one cycle
   // late. The interrupt lines are levels: flag and enable both high.
   // Reserved select code 11 stops the counter, the same as off.
   //
   // The pin enable follows the output enable bit. With the bit clear the
   // pin belongs to general-purpose I/O and the level output is only
   // meaningful while the enable output is high.
   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   if (tick_div < 2) begin : g_bad_div
      $error("tick_div must be at least 2");
   end
   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [1:0] clk_sel_r; // Counter clock select
   logic ovf_r; // Overflow flag
   logic ovf_clr_pend_r; // Read seen, drop flag on next tick
   logic overflow_irq_enable_r; // Overflow request enable
   logic compare_irq_enable_r; // Compare request enable
   logic [11:0] counter_r; // Up-counter
   logic [11:0] reload_r; // Auto-reload value
   logic oe_r; // PWM mode / pin drive
   logic polarity_r; // Output inversion
   logic cmpf_r; // Compare flag
   logic [11:0] duty_r; // Duty preload registers
   logic [11:0] shadow_r; // Active duty for PWM
   logic cmp_lock_r; // Compare held off after high write
   logic pwm_r; // Raw PWM level
   logic [31:0] div_r; // Lite tick divider
   // Bus pipeline
   logic wr_pend_r; // Write address phase seen, data due now
   logic [7:0] wr_idx_r; // Index of that write
   // Zero compare value disables compare mode
   localparam logic [11:0] word_zero = 12'h000;
   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   wire logic take = hsel && hready && htrans == autoreload_timer_pkg::htrans_nonseq;
   wire logic [7:0] a_idx = haddr[9:2];
   wire logic rd_take = take && !hwrite;
   wire logic rd_csr = rd_take && a_idx == autoreload_timer_pkg::idx_timer_control_status;
   wire logic rd_chan = rd_take && a_idx == autoreload_timer_pkg::idx_channel_control_status;
   wire logic [7:0] wbyte = hwdata[7:0];
   wire logic wr_csr = wr_pend_r && wr_idx_r == autoreload_timer_pkg::idx_timer_control_status;
   wire logic wr_rh = wr_pend_r && wr_idx_r == autoreload_timer_pkg::idx_reload_high;
   wire logic wr_rl = wr_pend_r && wr_idx_r == autoreload_timer_pkg::idx_reload_low;
   wire logic wr_oc = wr_pend_r && wr_idx_r == autoreload_timer_pkg::idx_output_control;
   wire logic wr_cc = wr_pend_r && wr_idx_r == autoreload_timer_pkg::idx_channel_control_status;
   wire logic wr_dh = wr_pend_r && wr_idx_r == autoreload_timer_pkg::idx_duty_high;
   wire logic wr_dl = wr_pend_r && wr_idx_r == autoreload_timer_pkg::idx_duty_low;
   // ---------------------------------------------------------------
   // Counter clock enable
   // ---------------------------------------------------------------
   wire logic lite_tick = div_r == 32'(tick_div - 1);
   // Reserved code 11 stops the counter like off
   wire logic cnt_en = (clk_sel_r == autoreload_timer_pkg::clk_cpu) ||
                       (clk_sel_r == autoreload_timer_pkg::clk_lite && lite_tick);
   wire logic wrap = cnt_en && counter_r == autoreload_timer_pkg::count_max;
   wire logic [11:0] counter_nxt = wrap ? reload_r : counter_r + 12'h001;
   // Compare target: shadow in PWM mode, preload in compare mode
   wire logic [11:0] cmp_target = oe_r ? shadow_r : duty_r;
   // Compare mode works only for nonzero values; locked between byte writes
   wire logic match = cnt_en && !cmp_lock_r && counter_nxt == cmp_target &&
                      (oe_r || duty_r != word_zero);
   // Lite divider free-runs while the lite tick is selected
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_r <= 32'h0000_0000;
      end else if (lite_tick || clk_sel_r != autoreload_timer_pkg::clk_lite) begin
         div_r <= 32'h0000_0000;
      end else begin
         div_r <= div_r + 32'h0000_0001;
      end
   end
   // Counter and shadow
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         counter_r <= autoreload_timer_pkg::word_reset;
         shadow_r <= autoreload_timer_pkg::word_reset;
      end else if (cnt_en) begin
         counter_r <= counter_nxt;
         if (wrap) begin
            shadow_r <= duty_r;
         end
      end
   end
   // PWM level: high on wrap, low on match (match wins for duty equal to reload)
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwm_r <= 1'b0;
      end else if (!oe_r) begin
         pwm_r <= 1'b0;
      end else if (match) begin
         pwm_r <= 1'b0;
      end else if (wrap) begin
         pwm_r <= 1'b1;
      end
   end
   // ---------------------------------------------------------------
   // Overflow flag: set wins; clear by read lands on the next tick
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ovf_r <= 1'b0;
         ovf_clr_pend_r <= 1'b0;
      end else if (wrap) begin
         ovf_r <= 1'b1;
         ovf_clr_pend_r <= 1'b0;
      end else if (ovf_clr_pend_r && cnt_en) begin
         ovf_r <= 1'b0;
         ovf_clr_pend_r <= 1'b0;
      end else if (rd_csr && ovf_r) begin
         ovf_clr_pend_r <= 1'b1;
      end
   end
   // Compare flag: set on match, cleared by reading channel status
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmpf_r <= 1'b0;
      end else if (match) begin
         cmpf_r <= 1'b1;
      end else if (rd_chan) begin
         cmpf_r <= 1'b0;
      end
   end
   // ---------------------------------------------------------------
   // Software-written registers
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_sel_r <= autoreload_timer_pkg::clk_off;
         overflow_irq_enable_r <= 1'b0;
         compare_irq_enable_r <= 1'b0;
         reload_r <= autoreload_timer_pkg::word_reset;
         oe_r <= 1'b0;
         polarity_r <= 1'b0;
         duty_r <= autoreload_timer_pkg::word_reset;
         cmp_lock_r <= 1'b0;
      end else begin
         if (wr_csr) begin
            clk_sel_r <= wbyte[autoreload_timer_pkg::clk_sel_hi:autoreload_timer_pkg::clk_sel_lo];
            overflow_irq_enable_r <= wbyte[autoreload_timer_pkg::overflow_irq_enable_bit];
            compare_irq_enable_r <= wbyte[autoreload_timer_pkg::compare_irq_enable_bit];
         end
         if (wr_rh) begin
            reload_r[11:8] <= wbyte[3:0];
         end
         if (wr_rl) begin
            reload_r[7:0] <= wbyte;
         end
         if (wr_oc) begin
            oe_r <= wbyte[autoreload_timer_pkg::oe_bit];
         end
         if (wr_cc) begin
            polarity_r <= wbyte[autoreload_timer_pkg::polarity_bit];
         end
         if (wr_dh) begin
            duty_r[11:8] <= wbyte[3:0];
            cmp_lock_r <= 1'b1;
         end
         if (wr_dl) begin
            duty_r[7:0] <= wbyte;
            cmp_lock_r <= 1'b0;
         end
      end
   end
   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      unique case (a_idx)
         autoreload_timer_pkg::idx_timer_control_status:
            rd_byte = {3'h0, clk_sel_r, ovf_r, overflow_irq_enable_r, compare_irq_enable_r};
         autoreload_timer_pkg::idx_counter_high: rd_byte = {4'h0, counter_r[11:8]};
         autoreload_timer_pkg::idx_counter_low: rd_byte = counter_r[7:0];
         autoreload_timer_pkg::idx_reload_high: rd_byte = {4'h0, reload_r[11:8]};
         autoreload_timer_pkg::idx_reload_low: rd_byte = reload_r[7:0];
         autoreload_timer_pkg::idx_output_control: rd_byte = {7'h00, oe_r};
         autoreload_timer_pkg::idx_channel_control_status: rd_byte = {6'h00, polarity_r, cmpf_r};
         autoreload_timer_pkg::idx_duty_high: rd_byte = {4'h0, duty_r[11:8]};
         autoreload_timer_pkg::idx_duty_low: rd_byte = duty_r[7:0];
         default: rd_byte = 8'h00; // Unmapped reads as zero
      endcase
   end
   // ---------------------------------------------------------------
   // Bus answer
   // ---------------------------------------------------------------
   // Zero wait states, always OKAY; ready and response never move.
   // The index is captured on every edge but only used when the
   // pending flag says a write address phase was taken.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_idx_r <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend_r <= take && hwrite;
         wr_idx_r <= a_idx;
         hrdata <= rd_take ? {24'h000000, rd_byte} : 32'h0000_0000;
      end
   end
   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse_output <= 1'b0;
         pulse_output_oe <= 1'b0;
         overflow_irq <= 1'b0;
         compare_irq <= 1'b0;
      end else begin
         pulse_output <= pwm_r ^ polarity_r;
         pulse_output_oe <= oe_r;
         overflow_irq <= ovf_r && overflow_irq_enable_r;
         compare_irq <= cmpf_r && compare_irq_enable_r;
      end
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   // All checks run on the bus clock and are off during reset.
   // Each watches internal state or a registered output; only a_ovf_lingers also uses bus inputs, through rd_csr.
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_wrap_reloads: assert property (wrap |=> counter_r == $past(reload_r))
      else $error("counter did not reload on wrap");
   a_wrap_sets_ovf: assert property (wrap |=> ovf_r)
      else $error("overflow flag not set on wrap");
   a_ovf_irq_gate: assert property (##1 overflow_irq == $past(ovf_r && overflow_irq_enable_r))
      else $error("overflow request mismatch");
   a_cmp_irq_gate: assert property (compare_irq |-> $past(compare_irq_enable_r))
      else $error("compare request without enable");
   a_ovf_lingers: assert property (rd_csr && ovf_r && !wrap |=> ovf_r)
      else $error("overflow flag dropped at once");
   a_off_holds: assert property (clk_sel_r == autoreload_timer_pkg::clk_off |=> $stable(counter_r))
      else $error("counter moved while off");
   a_match_sets_cmpf: assert property (match |=> cmpf_r)
      else $error("compare flag not set");
   a_lock_blocks: assert property (cmp_lock_r |-> !match)
      else $error("compare while locked");
   a_pin_release: assert property (!oe_r |=> !pulse_output_oe)
      else $error("pin driven while disabled");
   c_wrap: cover property (wrap);
   c_match_pwm: cover property (match && oe_r);
   c_match_cmp: cover property (match && !oe_r);
   c_ovf_clear: cover property (ovf_clr_pend_r && cnt_en);
   c_pwm_high: cover property (wrap && oe_r && !match);
endmodule // autoreload_timer_pwm

/* File: tb/tb_autoreload_timer_pwm.sv */
// Self-checking bench for the auto-reload timer with PWM channel
`timescale 1ns/1ns
module tb_autoreload_timer_pwm;
   // ---------------------------------------------
   // Bus signals, outputs, score
   // ---------------------------------------------
   logic hclk = 1'h0;
   logic hresetn = 1'h0; // Held low for two edges
   logic hsel = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [2:0] hsize = autoreload_timer_pkg::hsize_word;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout; // Also fed back as the bus hready
   logic hresp;
   logic pulse_output;
   logic pulse_output_oe;
   logic overflow_irq;
   logic compare_irq;
   int n_errors = 0;
   int tests_run = 0;
   int n; // Edges counted by the last wait
   logic [31:0] d; // Last read word
   logic [31:0] junk; // Read data of a write, unused
   // Short aliases of the register indices
   localparam logic [7:0] ctl = autoreload_timer_pkg::idx_timer_control_status;
   localparam logic [7:0] cnt_hi = autoreload_timer_pkg::idx_counter_high;
   localparam logic [7:0] cnt_lo = autoreload_timer_pkg::idx_counter_low;
   localparam logic [7:0] rld_hi = autoreload_timer_pkg::idx_reload_high;
   localparam logic [7:0] rld_lo = autoreload_timer_pkg::idx_reload_low;
   localparam logic [7:0] outc = autoreload_timer_pkg::idx_output_control;
   localparam logic [7:0] chan = autoreload_timer_pkg::idx_channel_control_status;
   localparam logic [7:0] dty_hi = autoreload_timer_pkg::idx_duty_high;
   localparam logic [7:0] dty_lo = autoreload_timer_pkg::idx_duty_low;
   // Short lite tick keeps the run brief
   autoreload_timer_pwm #(.tick_div(4)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pulse_output(pulse_output), .pulse_output_oe(pulse_output_oe),
      .overflow_irq(overflow_irq), .compare_irq(compare_irq)
   );
   // 125 MHz clock
   initial begin
      forever #4 hclk = ~hclk;
   end
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      if (n_errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic hang();
      n_errors++;
      $display("ERROR %0t: wait ran out", $time);
      conclude();
   endtask
   // Waits at least one edge, until ready is sampled high
   task automatic wait_ready();
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
         if (k > 50) begin
            hang();
         end
      end while (hreadyout !== 1'h1);
   endtask
   // Single word transfer, entered just after a rising edge
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'h1;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= wr;
      htrans <= autoreload_timer_pkg::htrans_nonseq;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata; // Taken at the closing edge
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      bus(1'h1, idx, {24'h0, v}, junk);
   endtask
   task automatic rd(input logic [7:0] idx);
      bus(1'h0, idx, 32'h0, d);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      rd(idx);
      check(d, {24'h0, exp});
   endtask
   // 0 pin level, 1 overflow request, 2 compare request
   function automatic logic watched(input int k);
      return (k == 0) ? pulse_output : ((k == 1) ? overflow_irq : compare_irq);
   endfunction
   // Counts edges until the signal shows v; bounded
   task automatic wait_for(input int k, input logic v, input int lim);
      n = 0;
      do begin
         @(posedge hclk);
         n++;
         if (n > lim) begin
            hang();
         end
      end while (watched(k) !== v);
   endtask
   // Signal must stay low for the whole span
   task automatic quiet(input int k, input int cycles);
      logic hit;
      hit = 1'h0;
      repeat (cycles) begin
         @(posedge hclk);
         hit = hit | (watched(k) !== 1'h0);
      end
      check(hit, 32'h0);
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset();
      logic [7:0] idx [10];
      idx = '{ctl, cnt_hi, cnt_lo, rld_hi, rld_lo, outc, chan, dty_hi, dty_lo, 8'h14};
      check({hreadyout, hresp, pulse_output, pulse_output_oe, overflow_irq, compare_irq}, 32'h20);
      foreach (idx[i]) begin
         rdc(idx[i], 8'h00);
      end
      wr(cnt_lo, 8'h55);
      rdc(cnt_lo, 8'h00);
   endtask
   // Every select code over a 40 cycle window; lite tick is 4 cycles
   task automatic t_clock();
      logic [7:0] code [4];
      logic [7:0] step [4];
      logic [31:0] prev;
      code = '{8'h00, 8'h08, 8'h10, 8'h18};
      step = '{8'h00, 8'h0a, 8'h28, 8'h00};
      foreach (code[i]) begin
         wr(ctl, code[i]);
         rd(cnt_lo);
         prev = d;
         repeat (38) @(posedge hclk);
         rd(cnt_lo);
         check((d - prev) & 32'hff, {24'h0, step[i]});
      end
   endtask
   task automatic t_overflow();
      wr(rld_hi, 8'h08);
      wr(rld_lo, 8'h00);
      rdc(rld_hi, 8'h08);
      wr(ctl, 8'h12);
      wait_for(1, 1'h1, 5000);
      wr(ctl, 8'h12);
      rdc(ctl, 8'h16);
      rdc(ctl, 8'h12);
      check(overflow_irq, 32'h0);
      rd(cnt_lo);
      rdc(cnt_hi, 8'h08);
      wr(ctl, 8'h10);
      quiet(1, 2100);
      rdc(ctl, 8'h14);
   endtask
   // Period 0x800 cycles, duty 0xa00: high 0x200, low 0x600
   task automatic t_pwm();
      wr(outc, 8'h01);
      wr(dty_hi, 8'h0a);
      wr(dty_lo, 8'h00);
      wait_for(0, 1'h0, 5000);
      wait_for(0, 1'h1, 5000);
      wait_for(0, 1'h0, 5000);
      check(n, 32'h200);
      check(pulse_output_oe, 32'h1);
      wait_for(0, 1'h1, 5000);
      check(n, 32'h600);
      wr(chan, 8'h02);
      wait_for(0, 1'h0, 5000);
      wait_for(0, 1'h1, 5000);
      wait_for(0, 1'h0, 5000);
      check(n, 32'h600);
      rdc(chan, 8'h03);
      rdc(chan, 8'h02);
      wr(outc, 8'h00);
      wr(chan, 8'h00);
      repeat (2) @(posedge hclk);
      check({pulse_output_oe, pulse_output}, 32'h0);
   endtask
   task automatic t_compare();
      wr(ctl, 8'h11);
      wr(dty_hi, 8'h09);
      wr(dty_lo, 8'h00);
      rd(chan);
      wait_for(2, 1'h1, 2200);
      rdc(cnt_hi, 8'h09);
      rdc(chan, 8'h01);
      wr(dty_hi, 8'h0b);
      rd(chan);
      quiet(2, 4200);
      wr(dty_lo, 8'h00);
      wait_for(2, 1'h1, 2200);
      rdc(cnt_hi, 8'h0b);
      wr(dty_hi, 8'h00);
      wr(dty_lo, 8'h00);
      rd(chan);
      quiet(2, 4200);
      wr(ctl, 8'h10);
      wr(dty_hi, 8'h09);
      wr(dty_lo, 8'h00);
      rd(chan);
      quiet(2, 2100);
      rdc(chan, 8'h01);
   endtask
   // Reset, then the scenarios in turn
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      t_reset();
      t_clock();
      t_overflow();
      t_pwm();
      t_compare();
      conclude();
   end
endmodule // tb_autoreload_timer_pwm
